// ---- hdl/ascal_pkg.sv ----
// constants, types and register map of the start-up calibration block
// assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus
package ascal_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0]  IDX_COMPENSATION_CONTROL       = 10'h0A0;
    localparam logic [9:0]  IDX_VOLT_OFFSET    = 10'h0AA;
    localparam logic [9:0]  IDX_RESULT_BASE    = 10'h0B0;
    localparam logic [9:0]  IDX_TEMP_OFFSET    = 10'h0D0;
    localparam logic [9:0]  IDX_TEMP_GAIN      = 10'h0D1;
    localparam logic [9:0]  IDX_LIMIT_UPPER    = 10'h0E0;
    localparam logic [9:0]  IDX_LIMIT_LOWER    = 10'h0E1;
    localparam logic [9:0]  IDX_IRQ_STATUS     = 10'h0E2;
    localparam logic [9:0]  IDX_IRQ_MASK       = 10'h0E3;
    localparam logic [9:0]  IDX_TEMP_LAST      = 10'h0E4;

    // compensation_control fields
    localparam int          CTL_REQ_BIT        = 0;
    localparam int          CTL_DONE_BIT       = 1;
    localparam int          CTL_REQ_MASK_BIT   = 8;

    // interrupt status and mask fields
    localparam int          IRQ_AZ_BIT         = 0;
    localparam int          IRQ_CAL_BIT        = 1;
    localparam int          IRQ_W              = 2;

    // reset values
    localparam logic [7:0]  COMP_RST           = 8'h00;
    localparam logic [15:0] LIMIT_UPPER_RST    = 16'hFFFF;
    localparam logic [15:0] LIMIT_LOWER_RST    = 16'h0000;
    localparam logic [1:0]  IRQ_MASK_RST       = 2'h0;
    localparam logic [10:0] RESULT_RST         = 11'h000;

    // auto-zero length in die link clock rising edges
    localparam logic [11:0] AZ_LINK_EDGES      = 12'hD18;

    // amplifier offset results, one per gain setting
    localparam int          NUM_GAINS          = 8;
    localparam int          GAIN_IDX_W         = 3;
    localparam int          RESULT_W           = 11;
    localparam logic [2:0]  LAST_GAIN          = 3'h7;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RUN  = 4'h2,
        ST_COPY = 4'h4,
        ST_HOLD = 4'h8
    } ascal_state_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] value;
    } ascal_temp_type;

    typedef struct packed {
        logic                  valid;
        logic [GAIN_IDX_W-1:0] gain_idx;
        logic [RESULT_W-1:0]   value;
    } ascal_offset_type;

    typedef struct packed {
        logic       amp_autozero_active;
        logic [7:0] voltage_offset_comp;
        logic [7:0] temp_offset_comp;
        logic [7:0] temp_gain_comp;
    } ascal_comp_type;

endpackage : ascal_pkg

// ---- hdl/ascal_result_mem.sv ----
// storage of the per-gain amplifier offset results
// one write port, one read port with registered read data
`timescale 1ns/1ps
module ascal_result_mem
    import ascal_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  we,
    input  wire logic [GAIN_IDX_W-1:0] waddr,
    input  wire logic [RESULT_W-1:0]   wdata,
    input  wire logic [GAIN_IDX_W-1:0] raddr,
    output logic      [RESULT_W-1:0]   rdata
);

    logic [RESULT_W-1:0] mem [NUM_GAINS];

    // cleared on reset so results read as zero before the first auto-zero
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < NUM_GAINS; i++) begin
                mem[i] <= RESULT_RST;
            end
            rdata <= RESULT_RST;
        end else begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end

endmodule : ascal_result_mem

// ---- hdl/ascal_top.sv ----
// start-up calibration registers, amplifier auto-zero sequencer and calibration request
// assumes a single AHB-Lite master, die link clock on a pin, temperature and offset inputs on clk
`timescale 1ns/1ps
// Overview of operation
// - the device sets the done flag about 6.5 ms after the request and software polls for it.
// - the auto-zero sequence lasts 3352 die link clock cycles from request to completion.
// - software clears the done flag by writing one to it and the device clears it on that write.
// - at completion the device places the per-gain 11-bit offset results in readable registers.
// - the device raises the calibration request when the temperature leaves the limit range.
module ascal_top
    import ascal_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic             die_link_clock,
    input  wire ascal_temp_type   temp_in,
    input  wire ascal_offset_type amp_offset_in,
    output ascal_comp_type        comp_out,
    output logic                  irq
);

    // bus data phase
    logic                 dp_write;
    logic                 dp_read_mem;
    logic [9:0]           dp_idx;
    logic [31:0]          rdata_q;

    // registers
    logic                 az_request;
    logic                 done_flag;
    logic [7:0]           volt_offset;
    logic [7:0]           temp_offset;
    logic [7:0]           temp_gain;
    logic [15:0]          limit_upper;
    logic [15:0]          limit_lower;
    logic [15:0]          temp_last;
    logic [IRQ_W-1:0]     irq_status;
    logic [IRQ_W-1:0]     irq_mask;

    // sequencer
    ascal_state_type      state;
    ascal_state_type      next_state;
    logic [11:0]          az_count;
    logic [2:0]           copy_idx;
    logic                 link_sync1;
    logic                 link_sync2;
    logic                 link_prev;
    logic [RESULT_W-1:0]  stage [NUM_GAINS];
    logic [RESULT_W-1:0]  mem_rdata;

    // address phase decode
    wire                  addr_take    = hsel & htrans[1] & hready;
    wire [9:0]            ap_idx       = haddr[11:2];
    wire                  ap_is_result = (ap_idx[9:3] == IDX_RESULT_BASE[9:3]);

    // data phase write decode
    wire                  wr_ctl       = dp_write & (dp_idx == IDX_COMPENSATION_CONTROL);
    wire                  wr_vo        = dp_write & (dp_idx == IDX_VOLT_OFFSET);
    wire                  wr_ito       = dp_write & (dp_idx == IDX_TEMP_OFFSET);
    wire                  wr_itg       = dp_write & (dp_idx == IDX_TEMP_GAIN);
    wire                  wr_upper     = dp_write & (dp_idx == IDX_LIMIT_UPPER);
    wire                  wr_lower     = dp_write & (dp_idx == IDX_LIMIT_LOWER);
    wire                  wr_status    = dp_write & (dp_idx == IDX_IRQ_STATUS);
    wire                  wr_mask      = dp_write & (dp_idx == IDX_IRQ_MASK);

    // masked request writes: the request bit moves only where its mask bit is one
    wire                  req_set      = wr_ctl & hwdata[CTL_REQ_MASK_BIT] & hwdata[CTL_REQ_BIT];
    wire                  req_clr      = wr_ctl & hwdata[CTL_REQ_MASK_BIT] & ~hwdata[CTL_REQ_BIT];
    wire                  done_clr     = wr_ctl & hwdata[CTL_DONE_BIT];

    // sequencer events
    wire                  link_edge    = link_sync2 & ~link_prev;
    wire                  az_last_edge = link_edge & (az_count == (AZ_LINK_EDGES - 12'h001));
    wire                  copy_last    = (state == ST_COPY) & (copy_idx == LAST_GAIN);
    wire                  cal_event    = temp_in.valid & ((temp_in.value > limit_upper) |
                                                          (temp_in.value < limit_lower));
    wire [IRQ_W-1:0]      irq_set      = {cal_event, copy_last};
    wire [IRQ_W-1:0]      irq_clr      = wr_status ? hwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};

    // read data, picked in the address phase and registered
    wire [15:0]           ctl_rd       = {14'h0000, done_flag, az_request};
    wire [31:0]           next_rdata   =
        (ap_idx == IDX_COMPENSATION_CONTROL)    ? {16'h0000, ctl_rd}          :
        (ap_idx == IDX_VOLT_OFFSET) ? {24'h000000, volt_offset}   :
        (ap_idx == IDX_TEMP_OFFSET) ? {24'h000000, temp_offset}   :
        (ap_idx == IDX_TEMP_GAIN)   ? {24'h000000, temp_gain}     :
        (ap_idx == IDX_LIMIT_UPPER) ? {16'h0000, limit_upper}     :
        (ap_idx == IDX_LIMIT_LOWER) ? {16'h0000, limit_lower}     :
        (ap_idx == IDX_IRQ_STATUS)  ? {30'h00000000, irq_status}  :
        (ap_idx == IDX_IRQ_MASK)    ? {30'h00000000, irq_mask}    :
        (ap_idx == IDX_TEMP_LAST)   ? {16'h0000, temp_last}       :
                                      32'h00000000;

    // no wait states: every transfer finishes in its data phase
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = dp_read_mem ? {21'h000000, mem_rdata} : rdata_q;
    assign irq       = |(irq_status & irq_mask);

    // active only while link edges are counted
    assign comp_out  = '{amp_autozero_active: (state == ST_RUN),
                         voltage_offset_comp: volt_offset,
                         temp_offset_comp:    temp_offset,
                         temp_gain_comp:      temp_gain};

    always_ff @(posedge clk) begin
        if (srst) begin
            dp_write    <= 1'b0;
            dp_read_mem <= 1'b0;
            dp_idx      <= 10'h000;
            rdata_q     <= 32'h00000000;
        end else begin
            dp_write    <= addr_take & hwrite;
            dp_read_mem <= addr_take & ~hwrite & ap_is_result;
            dp_idx      <= addr_take ? ap_idx : 10'h000;
            rdata_q     <= (addr_take & ~hwrite) ? next_rdata : 32'h00000000;
        end
    end

    // software writes trims, limits and the mask into these; the block holds them and drives only the trims out
    always_ff @(posedge clk) begin
        if (srst) begin
            volt_offset <= COMP_RST;
            temp_offset <= COMP_RST;
            temp_gain   <= COMP_RST;
            limit_upper <= LIMIT_UPPER_RST;
            limit_lower <= LIMIT_LOWER_RST;
            irq_mask    <= IRQ_MASK_RST;
        end else begin
            if (wr_vo) volt_offset <= hwdata[7:0];
            if (wr_ito) temp_offset <= hwdata[7:0];
            if (wr_itg) temp_gain <= hwdata[7:0];
            if (wr_upper) limit_upper <= hwdata[15:0];
            if (wr_lower) limit_lower <= hwdata[15:0];
            if (wr_mask) irq_mask <= hwdata[IRQ_W-1:0];
        end
    end

    // sticky flags: a set in the cycle of a clear wins
    always_ff @(posedge clk) begin
        if (srst) begin
            done_flag  <= 1'b0;
            irq_status <= {IRQ_W{1'b0}};
            temp_last  <= 16'h0000;
        end else begin
            done_flag  <= copy_last | (done_flag & ~done_clr);
            irq_status <= irq_set | (irq_status & ~irq_clr);
            if (temp_in.valid) temp_last <= temp_in.value;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            az_request <= 1'b0;
        end else if (req_set) begin
            az_request <= 1'b1;
        end else if (req_clr) begin
            az_request <= 1'b0;
        end
    end

    // die link clock is only sampled, never used as a clock
    // only the second flop and link_prev feed logic; the first may settle late
    always_ff @(posedge clk) begin
        if (srst) begin
            link_sync1 <= 1'b0;
            link_sync2 <= 1'b0;
            link_prev  <= 1'b0;
        end else begin
            link_sync1 <= die_link_clock;
            link_sync2 <= link_sync1;
            link_prev  <= link_sync2;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (req_set) next_state = ST_RUN;
            end
            ST_RUN: begin
                // dropping the request mid-run aborts without results
                if (!az_request) next_state = ST_IDLE;
                else if (az_last_edge) next_state = ST_COPY;
            end
            ST_COPY: begin
                if (copy_idx == LAST_GAIN) next_state = ST_HOLD;
            end
            ST_HOLD: begin
                if (!az_request) next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state    <= ST_IDLE;
            az_count <= 12'h000;
            copy_idx <= 3'h0;
        end else begin
            state    <= next_state;
            az_count <= (state != ST_RUN) ? 12'h000 : (link_edge ? az_count + 12'h001 : az_count);
            copy_idx <= (state == ST_COPY) ? copy_idx + 3'h1 : 3'h0;
        end
    end

    // offset results are staged during the run and published only at completion
    // a later result for the same gain overwrites the earlier one
    for (genvar g = 0; g < NUM_GAINS; g++) begin : g_stage
        always_ff @(posedge clk) begin
            if (srst) begin
                stage[g] <= RESULT_RST;
            end else if ((state == ST_RUN) && amp_offset_in.valid &&
                         (amp_offset_in.gain_idx == GAIN_IDX_W'(g))) begin
                stage[g] <= amp_offset_in.value;
            end
        end
    end

    ascal_result_mem ascal_result_mem_inst (
        .clk   (clk),
        .srst  (srst),
        .we    (state == ST_COPY),
        .waddr (copy_idx),
        .wdata (stage[copy_idx]),
        .raddr (ap_idx[2:0]),
        .rdata (mem_rdata)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence seq_run_ends;
        (state == ST_RUN) && az_request && az_last_edge;
    endsequence

    sequence seq_copy_walk;
        (state == ST_COPY) ##1 (state == ST_COPY) [*7];
    endsequence

    AST_START_ON_MASKED_WRITE: assert property ((state == ST_IDLE) && req_set |=> (state == ST_RUN))
        else $error("masked request write did not start auto-zero");
    AST_RUN_ENDS_AT_EDGE_COUNT: assert property (seq_run_ends |=> (state == ST_COPY))
        else $error("run did not end at the last link edge");
    AST_NO_EARLY_END: assert property ((state == ST_RUN) && az_request && !az_last_edge |=> (state == ST_RUN))
        else $error("run ended before the edge count");
    AST_DONE_AFTER_COPY: assert property (seq_run_ends ##1 seq_copy_walk |=> done_flag && (state == ST_HOLD))
        else $error("done flag not set after result copy");
    AST_DONE_CAUSE: assert property ($rose(done_flag) |-> $past(state) == ST_COPY)
        else $error("done flag rose outside completion");
    AST_DONE_W1C: assert property (done_flag && done_clr && !copy_last |=> !done_flag)
        else $error("write-one did not clear done flag");
    AST_DONE_STICKY: assert property (done_flag && !done_clr |=> done_flag)
        else $error("done flag dropped without a clear");
    AST_RESULT_PUBLISH: assert property ((state == ST_COPY) && (copy_idx == 3'h2) |=> ##1 (copy_idx == 3'h4))
        else $error("result copy did not walk the gain entries");
    AST_CAL_REQUEST: assert property (cal_event |=> irq_status[IRQ_CAL_BIT])
        else $error("out of range temperature did not flag calibration request");
    AST_CAL_IRQ_OUT: assert property (cal_event && irq_mask[IRQ_CAL_BIT] && !wr_mask |=> irq)
        else $error("enabled calibration request did not raise interrupt");

    // edge count bound, request handling, abort, completion and in-range temperature events
    AST_COUNT_BOUND: assert property ((state == ST_RUN) |-> (az_count < AZ_LINK_EDGES))
        else $error("link edge count ran past the auto-zero length");
    AST_REQ_NEEDS_MASK: assert property (wr_ctl && !hwdata[CTL_REQ_MASK_BIT] |=> $stable(az_request))
        else $error("request bit moved without its mask bit");
    AST_ABORT_TO_IDLE: assert property ((state == ST_RUN) && !az_request |=> (state == ST_IDLE))
        else $error("dropped request did not abort the run");
    AST_HOLD_EXIT: assert property ((state == ST_HOLD) && !az_request |=> (state == ST_IDLE))
        else $error("request written zero did not leave auto-zero");
    AST_AZ_EVENT: assert property (copy_last |=> irq_status[IRQ_AZ_BIT] && done_flag)
        else $error("completion did not set done flag and status");
    AST_CAL_IN_RANGE: assert property (temp_in.valid && !cal_event && !irq_status[IRQ_CAL_BIT] |=> !irq_status[IRQ_CAL_BIT])
        else $error("in range temperature flagged a calibration request");

endmodule : ascal_top

// ---- bench/ascal_testbench.sv ----
// self-checking bench for the start-up calibration block
// drives the AHB-Lite port, die link clock, temperature and offset inputs directly
`timescale 1ns/1ps
module testbench;
    import ascal_pkg::*;
    localparam int    LIMIT = 40000;
    logic             clk;
    logic             srst;
    logic             hsel;
    logic             hwrite;
    logic [1:0]       htrans;
    logic [31:0]      haddr;
    logic [31:0]      hwdata;
    logic [31:0]      hrdata;
    logic [31:0]      rd;
    logic             hreadyout;
    logic             hresp;
    logic             irq;
    logic             die_link_clock;
    logic             link_run;
    logic             link_div;
    int               link_edges;
    int               cycle_count;
    int               num_errors;
    int               checks;
    ascal_temp_type   temp_in;
    ascal_offset_type amp_offset_in;
    ascal_comp_type   comp_out;

    ascal_top ascal_top_inst (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .die_link_clock(die_link_clock), .temp_in(temp_in),
        .amp_offset_in(amp_offset_in), .comp_out(comp_out), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // link clock toggles every two cycles, only while an auto-zero is meant to run
    always @(posedge clk) begin
        cycle_count <= cycle_count + 1;
        if (link_run) begin
            link_div <= ~link_div;
            if (link_div) begin
                die_link_clock <= ~die_link_clock;
                if (!die_link_clock) link_edges <= link_edges + 1;
            end
        end
        if (cycle_count == LIMIT) begin
            num_errors++;
            tally_and_finish();
        end
    end

    function automatic logic [10:0] res_val(input int g);
        return {g[2:0], 8'h5A};
    endfunction : res_val

    // software side: gain table entry k of steps from a sign-magnitude trim, room difference zero
    function automatic logic [7:0] lut_entry(input logic [7:0] trim, input int k, input int steps);
        int v;
        v = (trim[7] ? -int'(trim[6:0]) : int'(trim[6:0])) * k / steps;
        return (v < 0) ? {1'b1, 7'(-v)} : {1'b0, 7'(v)};
    endfunction : lut_entry

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic bus_phase(input logic [9:0] idx, input logic wr);
        hsel <= 1'b1;
        haddr <= {20'h00000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
    endtask : bus_phase

    task automatic bus_write(input logic [9:0] idx, input logic [31:0] d);
        bus_phase(idx, 1'b1);
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
    endtask : bus_write

    task automatic bus_read(input logic [9:0] idx, output logic [31:0] d);
        bus_phase(idx, 1'b0);
        do @(posedge clk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : bus_read

    task automatic rd_check(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        bus_read(idx, v);
        check(v, exp);
    endtask : rd_check

    task automatic temp_pulse(input logic [15:0] v);
        temp_in <= {1'b1, v};
        @(posedge clk);
        temp_in <= '0;
        @(posedge clk);
    endtask : temp_pulse

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        {srst, hsel, hwrite, htrans, haddr, hwdata} = '0;
        srst = 1'b1;
        {die_link_clock, link_run, link_div, link_edges, cycle_count, num_errors, checks} = '0;
        temp_in = '0;
        amp_offset_in = '0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd_check(IDX_LIMIT_UPPER, 32'h0000FFFF);
        rd_check(IDX_LIMIT_LOWER, 32'h00000000);
        rd_check(IDX_IRQ_MASK, 32'h0);
        rd_check(IDX_COMPENSATION_CONTROL, 32'h0);
        rd_check(IDX_RESULT_BASE, 32'h0);
        check({7'h00, comp_out}, 32'h0);
        check({30'h0, hresp, hreadyout}, 32'h1);
        $display("test reset_values done");
        // upper bits written as ones must read back as zero
        bus_write(IDX_VOLT_OFFSET, 32'hFFFFFFA5);
        bus_write(IDX_TEMP_OFFSET, 32'hFFFFFF3C);
        bus_write(IDX_TEMP_GAIN, 32'hFFFFFFC3);
        rd_check(IDX_VOLT_OFFSET, 32'hA5);
        rd_check(IDX_TEMP_OFFSET, 32'h3C);
        rd_check(IDX_TEMP_GAIN, 32'hC3);
        check({7'h00, comp_out}, {7'h00, 1'b0, 8'hA5, 8'h3C, 8'hC3});
        bus_write(10'h3FF, 32'h12345678);
        rd_check(10'h3FF, 32'h0);
        bus_write(IDX_RESULT_BASE, 32'h7FF);
        rd_check(IDX_RESULT_BASE, 32'h0);
        bus_write(IDX_COMPENSATION_CONTROL, 32'h1);
        rd_check(IDX_COMPENSATION_CONTROL, 32'h0);
        $display("test registers done");
        bus_write(IDX_IRQ_MASK, 32'h1);
        link_run <= 1'b1;
        bus_write(IDX_COMPENSATION_CONTROL, 32'h101);
        rd_check(IDX_COMPENSATION_CONTROL, 32'h1);
        check({31'h0, comp_out.amp_autozero_active}, 32'h1);
        // offsets arrive as from a chopper-off run at top decimation with the filter on
        amp_offset_in <= {1'b1, 3'h3, 11'h111};
        for (int g = 0; g < NUM_GAINS; g++) begin
            @(posedge clk);
            amp_offset_in <= {1'b1, 3'(g), res_val(g)};
        end
        @(posedge clk);
        amp_offset_in <= '0;
        @(posedge clk);
        do bus_read(IDX_COMPENSATION_CONTROL, rd); while (rd[1] !== 1'b1);
        link_run <= 1'b0;
        check({31'h0, link_edges >= 3352 && link_edges <= 3358}, 32'h1);
        check(rd, 32'h3);
        check({31'h0, irq}, 32'h1);
        rd_check(IDX_IRQ_STATUS, 32'h1);
        for (int g = 0; g < NUM_GAINS; g++) rd_check(IDX_RESULT_BASE + 10'(g), {21'h0, res_val(g)});
        bus_write(IDX_COMPENSATION_CONTROL, 32'h100);
        rd_check(IDX_COMPENSATION_CONTROL, 32'h2);
        check({31'h0, comp_out.amp_autozero_active}, 32'h0);
        bus_write(IDX_COMPENSATION_CONTROL, 32'h2);
        rd_check(IDX_COMPENSATION_CONTROL, 32'h0);
        bus_write(IDX_IRQ_STATUS, 32'h1);
        rd_check(IDX_IRQ_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
        $display("test autozero done");
        // aborted run must leave no done flag and keep old results
        link_run <= 1'b1;
        bus_write(IDX_COMPENSATION_CONTROL, 32'h101);
        amp_offset_in <= {1'b1, 3'h2, 11'h7FF};
        @(posedge clk);
        amp_offset_in <= '0;
        repeat (400) @(posedge clk);
        bus_write(IDX_COMPENSATION_CONTROL, 32'h100);
        repeat (400) @(posedge clk);
        link_run <= 1'b0;
        rd_check(IDX_COMPENSATION_CONTROL, 32'h0);
        rd_check(IDX_RESULT_BASE + 10'h2, {21'h0, res_val(2)});
        $display("test abort done");
        bus_write(IDX_LIMIT_UPPER, 32'h0800);
        bus_write(IDX_LIMIT_LOWER, 32'h0200);
        bus_write(IDX_IRQ_MASK, 32'h2);
        rd_check(IDX_LIMIT_UPPER, 32'h0800);
        temp_pulse(16'h0800);
        rd_check(IDX_IRQ_STATUS, 32'h0);
        temp_pulse(16'h0801);
        check({31'h0, irq}, 32'h1);
        rd_check(IDX_IRQ_STATUS, 32'h2);
        rd_check(IDX_TEMP_LAST, 32'h0801);
        // first reading taken: table entries of trim 0x82 at the trim and halfway to it, and of trim 0x06 halfway
        check({24'h0, lut_entry(8'h82, 2, 2)}, 32'h82);
        check({24'h0, lut_entry(8'h82, 1, 2)}, 32'h81);
        check({24'h0, lut_entry(8'h06, 1, 2)}, 32'h03);
        bus_write(IDX_IRQ_STATUS, 32'h2);
        // the clear lands at the edge that ends the data phase
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        temp_pulse(16'h0200);
        rd_check(IDX_IRQ_STATUS, 32'h0);
        bus_write(IDX_IRQ_MASK, 32'h0);
        temp_pulse(16'h01FF);
        check({31'h0, irq}, 32'h0);
        rd_check(IDX_IRQ_STATUS, 32'h2);
        bus_write(IDX_IRQ_STATUS, 32'h2);
        rd_check(IDX_IRQ_STATUS, 32'h0);
        $display("test calibration_request done");
        tally_and_finish();
    end
endmodule : testbench
